/* File: lpb_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LPB_REGS_SVH
`define LPB_REGS_SVH

`define LPB_ADDR_COMMON      8'h45
`define LPB_ADDR_DUTY_FIRST  8'h50
`define LPB_ADDR_DUTY_LAST   8'h53
`define LPB_ADDR_CFG_FIRST   8'h54
`define LPB_ADDR_CFG_LAST    8'h57

`define LPB_DUTY_RESET       8'h00
`define LPB_CFG_RESET        6'h00
`define LPB_DUTY_FULL        8'hFF

`define LPB_CFG_COMMON_BIT   5
`define LPB_CFG_PERIOD_HI    4
`define LPB_CFG_PERIOD_LO    2
`define LPB_CFG_ONTIME_HI    1
`define LPB_CFG_ONTIME_LO    0

`define LPB_CODE_OFF         3'h0
`define LPB_CODE_MAX         3'h5
`define LPB_BLINK_BASE_MS    13'h100
`define LPB_FADE_STEP_MS     9'h010
`define LPB_FADE_STEPS       5'h10

`define LPB_CLK_HZ           10000000
`define LPB_TICK_MS          1
`define LPB_TICK_CYCLES      ((`LPB_CLK_HZ / 1000) * `LPB_TICK_MS)

`endif

/* File: lpb_pkg.sv */
// types shared by the led port intensity and blink block
package lpb_pkg;

  typedef enum logic [3:0] {
    FADE_OFF  = 4'b0001,
    FADE_UP   = 4'b0010,
    FADE_ON   = 4'b0100,
    FADE_DOWN = 4'b1000
  } lpb_fade_type;

  typedef struct packed {
    logic [3:0][7:0] duty;
    logic [3:0][5:0] cfg;
    logic [7:0]      common;
    logic [7:0]      pwmCnt;
    logic [15:0]     tickCnt;
    logic [11:0]     msCnt;
    logic [8:0]      stepCnt;
    logic [4:0]      level;
    lpb_fade_type    fade;
    logic [7:0]      rdData;
    logic            rdHit;
  } lpb_state_type;

  typedef struct packed {
    logic sinkOn;
  } lpb_chan_state_type;

endpackage : lpb_pkg

/* File: lpb_channel.sv */
// one led port: duty compare gated by the blink window
`timescale 1ns/1ps
`include "lpb_regs.svh"

module lpb_channel
  import lpb_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // shared timing
  input  wire logic [7:0] pwmCnt,
  input  wire logic [11:0] msCnt,
  input  wire logic       active,
  // port settings
  input  wire logic [7:0] duty,
  input  wire logic [2:0] blinkCode,
  input  wire logic [1:0] onCode,
  // sink control
  output logic            sinkOn
);

  lpb_chan_state_type s_q;
  lpb_chan_state_type s_d;

  logic [12:0] period;
  logic [12:0] onLen;
  logic [11:0] phase;
  logic        pwmOk;
  logic        blinkOk;

  always_comb
  begin
    s_d     = s_q;
    period  = `LPB_BLINK_BASE_MS << (blinkCode - 3'h1);
    onLen   = period >> (3'({1'b0, onCode}) + 3'h1);
    phase   = msCnt & (period[11:0] - 12'h001);
    pwmOk   = (duty == `LPB_DUTY_FULL) || (pwmCnt < duty);
    // undefined period codes treated as no blink
    if ((blinkCode == `LPB_CODE_OFF) || (blinkCode > `LPB_CODE_MAX))
    begin
      blinkOk = 1'b1;
    end
    else
    begin
      blinkOk = ({1'b0, phase} < onLen);
    end
    s_d.sinkOn = active && pwmOk && blinkOk;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sinkOn = s_q.sinkOn;

endmodule : lpb_channel

/* File: lpb_led_control.sv */
// intensity, blink and fade control for four open-drain led ports
`timescale 1ns/1ps
`include "lpb_regs.svh"

module lpb_led_control
  import lpb_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(`LPB_TICK_CYCLES)
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // register port from the serial front end
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic [7:0]      regRdData,
  output logic            regRdHit,
  // global controls owned by the device configuration unit
  input  wire logic       runEnable,
  input  wire logic [2:0] fadeCode,
  // open-drain sinks: led_port_a .. led_port_d on bits 0 .. 3
  output logic [3:0]      ledSinkOut,
  output logic [3:0]      ledSinkOe
);

  lpb_state_type s_q;
  lpb_state_type s_d;

  logic [12:0] fadeProd;
  logic [7:0]  fadedCommon;
  logic [8:0]  stepLimit;
  logic        msTick;
  logic        fadeUsed;
  logic        active;
  logic        wrOk;
  logic [3:0]  sinkOn;
  logic [3:0][7:0] portDuty;

  always_comb
  begin
    s_d = s_q;

    // shared timing base
    s_d.pwmCnt = s_q.pwmCnt + 8'h01;
    msTick     = (s_q.tickCnt == TICK_CYCLES - 16'h0001);
    if (msTick)
    begin
      s_d.tickCnt = 16'h0000;
      // 12 bits wrap at 4096 ms, a multiple of every blink period
      s_d.msCnt   = s_q.msCnt + 12'h001;
    end
    else
    begin
      s_d.tickCnt = s_q.tickCnt + 16'h0001;
    end

    // register writes are frozen while the block is shut down
    wrOk = regWrEn && runEnable;
    if (wrOk)
    begin
      if (regAddr == `LPB_ADDR_COMMON)
      begin
        s_d.common = regWrData;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (regAddr == `LPB_ADDR_DUTY_FIRST + 8'(i))
        begin
          s_d.duty[i] = regWrData;
        end
        if (regAddr == `LPB_ADDR_CFG_FIRST + 8'(i))
        begin
          s_d.cfg[i] = regWrData[5:0];
        end
      end
    end

    // reads answer one cycle later, unmapped addresses read zero
    if (regRdEn)
    begin
      s_d.rdData = 8'h00;
      s_d.rdHit  = 1'b0;
      if (regAddr == `LPB_ADDR_COMMON)
      begin
        s_d.rdData = s_q.common;
        s_d.rdHit  = 1'b1;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (regAddr == `LPB_ADDR_DUTY_FIRST + 8'(i))
        begin
          s_d.rdData = s_q.duty[i];
          s_d.rdHit  = 1'b1;
        end
        if (regAddr == `LPB_ADDR_CFG_FIRST + 8'(i))
        begin
          s_d.rdData = {2'b00, s_q.cfg[i]};
          s_d.rdHit  = 1'b1;
        end
      end
    end

    // fade sequencer; undefined fade codes behave as no fade
    fadeUsed  = (fadeCode != `LPB_CODE_OFF) && (fadeCode <= `LPB_CODE_MAX);
    stepLimit = `LPB_FADE_STEP_MS << (fadeCode - 3'h1);
    if (msTick)
    begin
      s_d.stepCnt = s_q.stepCnt + 9'h001;
    end

    case (s_q.fade)
      FADE_OFF:
      begin
        s_d.level   = 5'h00;
        s_d.stepCnt = 9'h000;
        if (runEnable && fadeUsed)
        begin
          s_d.fade = FADE_UP;
        end
        else if (runEnable)
        begin
          s_d.level = `LPB_FADE_STEPS;
          s_d.fade  = FADE_ON;
        end
      end
      FADE_UP:
      begin
        if (!runEnable)
        begin
          s_d.fade = fadeUsed ? FADE_DOWN : FADE_OFF;
          s_d.stepCnt = 9'h000;
        end
        else if (!fadeUsed)
        begin
          s_d.level = `LPB_FADE_STEPS;
          s_d.fade  = FADE_ON;
        end
        else if (msTick && (s_q.stepCnt >= stepLimit - 9'h001))
        begin
          // one of 16 equal steps toward the shared duty
          s_d.stepCnt = 9'h000;
          s_d.level   = s_q.level + 5'h01;
          if (s_q.level == `LPB_FADE_STEPS - 5'h01)
          begin
            s_d.fade = FADE_ON;
          end
        end
      end
      FADE_ON:
      begin
        s_d.stepCnt = 9'h000;
        s_d.level   = `LPB_FADE_STEPS;
        if (!runEnable)
        begin
          s_d.fade = fadeUsed ? FADE_DOWN : FADE_OFF;
        end
      end
      FADE_DOWN:
      begin
        if (runEnable)
        begin
          s_d.fade    = FADE_UP;
          s_d.stepCnt = 9'h000;
        end
        else if (!fadeUsed)
        begin
          s_d.fade = FADE_OFF;
        end
        else if (msTick && (s_q.stepCnt >= stepLimit - 9'h001))
        begin
          s_d.stepCnt = 9'h000;
          s_d.level   = s_q.level - 5'h01;
          if (s_q.level == 5'h01)
          begin
            s_d.fade = FADE_OFF;
          end
        end
      end
      default:
      begin
        s_d.fade  = FADE_OFF;
        s_d.level = 5'h00;
      end
    endcase
  end

  // shared duty scaled by fade level; level 16 returns it unchanged
  assign fadeProd    = {5'h00, s_q.common} * {8'h00, s_q.level};
  assign fadedCommon = fadeProd[11:4];

  // sinks stay alive during a fade-out, then shut down
  assign active = runEnable || (s_q.fade == FADE_DOWN);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_q      <= '0;
      s_q.fade <= FADE_OFF;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_port
      assign portDuty[g] = s_q.cfg[g][`LPB_CFG_COMMON_BIT] ?
                           fadedCommon : s_q.duty[g];
      lpb_channel u_chan (
        .core_clk  (core_clk),
        .srst      (srst),
        .pwmCnt    (s_q.pwmCnt),
        .msCnt     (s_q.msCnt),
        .active    (active),
        .duty      (portDuty[g]),
        .blinkCode (s_q.cfg[g][`LPB_CFG_PERIOD_HI:`LPB_CFG_PERIOD_LO]),
        .onCode    (s_q.cfg[g][`LPB_CFG_ONTIME_HI:`LPB_CFG_ONTIME_LO]),
        .sinkOn    (sinkOn[g])
      );
    end
  endgenerate

  // an open-drain sink only ever pulls low
  assign ledSinkOut = 4'h0;
  assign ledSinkOe  = sinkOn;
  assign regRdData  = s_q.rdData;
  assign regRdHit   = s_q.rdHit;

endmodule : lpb_led_control

/* File: lpb_props.sv */
// port assertions for the led intensity and blink block
`timescale 1ns/1ps
module lpb_props
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       regRdHit,
  // global controls
  input wire logic       runEnable,
  input wire logic [2:0] fadeCode,
  // sinks
  input wire logic [3:0] ledSinkOut,
  input wire logic [3:0] ledSinkOe
);
  logic mapped;
  assign mapped = regAddr == 8'h45 || regAddr[7:3] == 5'h0A;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_od; ledSinkOut == 4'h0; endproperty
  a_od: assert property (p_od) else $error("sink drive not low");
  property p_miss; regRdEn && !mapped |=> regRdData == 8'h00 && !regRdHit;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_hit; regRdEn && mapped |=> regRdHit; endproperty
  a_hit: assert property (p_hit) else $error("mapped read missed");
  property p_hold; !regRdEn |=> $stable(regRdData) && $stable(regRdHit);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_top; regRdEn && regAddr[7:2] == 6'h15 |=> regRdData[7:6] == 2'b00;
  endproperty
  a_top: assert property (p_top) else $error("config top bits");
  // write, one quiet cycle, then a read of the same address
  property p_wr; regWrEn && runEnable && mapped && regAddr[7:2] != 6'h15
    ##1 !regWrEn ##1 regRdEn && regAddr == $past(regAddr, 2)
    |=> regRdData == $past(regWrData, 3);
  endproperty
  a_wr: assert property (p_wr) else $error("readback differs");
  property p_off; (!runEnable && fadeCode == 3'h0) [*4] |-> ledSinkOe == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("sink on while stopped");
  property p_rst; $fell(srst) |-> ledSinkOe == 4'h0 && regRdData == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : lpb_props
bind lpb_led_control lpb_props chk_u (.*);

/* File: lpb_led_model.sv */
// led sink model: counts the cycles each open-drain port conducts
`timescale 1ns/1ps
module lpb_led_model
(
  // clock and control
  input  wire logic             core_clk,
  input  wire logic             clr,
  // sink pins
  input  wire logic [3:0]       ledSinkOut,
  input  wire logic [3:0]       ledSinkOe,
  // on-cycle counts
  output logic      [3:0][15:0] cnt
);
  // pin rests high through the led unless the sink pulls it low
  always_ff @(posedge core_clk)
    for (int k = 0; k < 4; k++)
      cnt[k] <= clr ? 16'h0000 : cnt[k] + 16'(ledSinkOe[k] && !ledSinkOut[k]);
endmodule : lpb_led_model

/* File: lpb_led_control_tb_top.sv */
// testbench for the led intensity and blink block
`timescale 1ns/1ps
module lpb_led_control_tb_top;
  logic             core_clk, srst, regWrEn, regRdEn, runEnable, clr;
  logic [7:0]       regAddr, regWrData, regRdData;
  logic             regRdHit;
  logic [2:0]       fadeCode;
  logic [3:0]       ledSinkOut, ledSinkOe;
  logic [3:0][15:0] cnt;
  int               failures, cmp_count, i;
  lpb_led_control #(.TICK_CYCLES(16'h0004)) dut_u (.core_clk(core_clk),
    .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdHit(regRdHit), .runEnable(runEnable), .fadeCode(fadeCode),
    .ledSinkOut(ledSinkOut), .ledSinkOe(ledSinkOe));
  lpb_led_model led_u (.core_clk(core_clk), .clr(clr),
    .ledSinkOut(ledSinkOut), .ledSinkOe(ledSinkOe), .cnt(cnt));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rdck(input logic [7:0] a, input logic [7:0] d, input bit h);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    check(16'(regRdData), 16'(d));
    check(16'(regRdHit), 16'(h));
  endtask : rdck
  // port a skipped at FFFF; others only over whole pwm periods
  task automatic lit(input int win, input logic [15:0] exA, input int k);
    repeat (4) @(negedge core_clk);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    repeat (win) @(negedge core_clk);
    if (exA !== 16'hFFFF) check(cnt[0], exA);
    if (win % 256 == 0)
    begin
      check(cnt[1], 16'(k * 2 * win / 256));
      check(cnt[2], 16'(k * 254 * win / 256));
      check(cnt[3], 16'(k * win));
    end
  endtask : lit
  task automatic give_verdict();
    $display("compares %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    #6000000;
    failures++;
    give_verdict();
  end
  initial
  begin
    {srst, regWrEn, regRdEn, runEnable, clr} = 5'b10000;
    {regAddr, regWrData, fadeCode} = 19'h00000;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    rdck(8'h45, 8'h00, 1'b1);
    for (i = 0; i < 8; i++) rdck(8'(8'h50 + i), 8'h00, 1'b1);
    rdck(8'h44, 8'h00, 1'b0);
    rdck(8'h58, 8'h00, 1'b0);
    runEnable = 1'b1;
    for (i = 0; i < 4; i++) wr(8'(8'h54 + i), 8'hFF);
    for (i = 0; i < 4; i++) rdck(8'(8'h54 + i), 8'h3F, 1'b1);
    for (i = 0; i < 4; i++) wr(8'(8'h54 + i), 8'h00);
    wr(8'h51, 8'h02);
    wr(8'h52, 8'hFE);
    wr(8'h53, 8'hFF);
    rdck(8'h53, 8'hFF, 1'b1);
    lit(256, 16'h0000, 1);
    wr(8'h45, 8'h10);
    wr(8'h54, 8'h20);
    lit(256, 16'h0010, 1);
    wr(8'h54, 8'h00);
    wr(8'h50, 8'hFF);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h54, 8'h04 | i[7:0]);
      lit(1024, 16'(512 >> i), 1);
    end
    for (i = 1; i < 6; i++)
    begin
      wr(8'h54, 8'(i << 2) | 8'h03);
      lit(1024 << (i - 1), 16'(64 << (i - 1)), 1);
    end
    wr(8'h54, 8'h20);
    wr(8'h45, 8'hFF);
    lit(256, 16'h0100, 1);
    runEnable = 1'b0;
    lit(256, 16'h0000, 0);
    wr(8'h51, 8'h55);
    rdck(8'h51, 8'h02, 1'b1);
    fadeCode = 3'h1;
    runEnable = 1'b1;
    lit(200, 16'hFFFF, 0);
    check(16'(cnt[0] < 16'd128), 16'h0001);
    repeat (1300) @(negedge core_clk);
    lit(256, 16'h0100, 1);
    runEnable = 1'b0;
    repeat (1300) @(negedge core_clk);
    lit(256, 16'h0000, 0);
    give_verdict();
  end
endmodule : lpb_led_control_tb_top
